// file: hw/sas_sequencer.sv
/*
 Top of the converter sequencer: mode, result and pin select registers on the
 internal register port, start and trigger control, conversion pacing and the
 hold and sample controls for the analog front end.
 Assumes the comparator answer is synchronous to clk_sys and valid within one
 bit slot of a new trial code.
*/
module sas_sequencer
   import sas_pkg::*;
(
   // Clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  reset_n,
   // Register port
   input  wire sas_bus_req_s          bus_req,
   output      logic [DATA_W-1:0]     bus_rdata,
   // External trigger
   input  wire logic                  ext_trigger_in,
   // Analog front end
   input  wire logic                  cmp_ge,
   output      logic [DATA_W-1:0]     trial_code,
   output      logic                  sample_en,
   output      logic                  hold_en,
   output      logic [CHAN_W-1:0]     chan_sel,
   output      logic [CHAN_COUNT-1:0] analog_pin_en,
   // Completion
   output      logic                  conv_done_irq
);

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------

   function automatic logic [DATA_W-1:0] apply_write(
      input logic [DATA_W-1:0] old_val,
      input sas_bus_req_s      req
   );
      logic [DATA_W-1:0] new_val;
      new_val = old_val;
      if (req.bit_op) begin
         new_val[req.bit_sel] = req.bit_val;
      end else begin
         new_val = req.wdata;
      end
      return new_val;
   endfunction

   // Code 11 is prohibited; it runs as the longest setting so a mistaken
   // write errs toward a slower, still valid conversion.
   function automatic logic [SLOT_W-1:0] slot_len(input logic [1:0] sel);
      logic [SLOT_W-1:0] len;
      len = SLOT_LONG;
      case (sel)
         TSEL_STD:  len = SLOT_STD;
         TSEL_FAST: len = SLOT_FAST;
         TSEL_LONG: len = SLOT_LONG;
         default:   len = SLOT_LONG;
      endcase
      return len;
   endfunction

   // ---------------------------------------------------------------
   // Declarations
   // ---------------------------------------------------------------

   sas_mode_s             mode;
   sas_mode_s             next_mode;

   logic [PIN_CNT_W-1:0]  pin_count;
   logic [PIN_CNT_W-1:0]  next_pin_count;
   logic [CHAN_COUNT-1:0] next_pin_en;

   logic [DATA_W-1:0]     result;
   logic [DATA_W-1:0]     next_rdata;

   logic                  mode_sel;
   logic                  result_sel;
   logic                  pin_sel_sel;

   logic                  mode_wr;
   logic                  pin_wr;

   sas_state_e            state;
   sas_state_e            next_state;

   logic [SLOT_W-1:0]     cnt;
   logic [SLOT_W-1:0]     next_cnt;
   logic [SLOT_W-1:0]     slot_q;
   logic [SLOT_W-1:0]     new_slot;

   logic [CHAN_W-1:0]     bit_idx;
   logic [1:0]            start_time_sel;

   logic                  trig_enable;
   logic                  trig_pulse;

   logic                  cnt_zero;
   logic                  begin_conv;
   logic                  sample_end;
   logic                  bit_decide;
   logic                  last_decide;

   // ---------------------------------------------------------------
   // Register decode
   // ---------------------------------------------------------------

   assign mode_sel    = (bus_req.addr == MODE_ADDR);
   assign result_sel  = (bus_req.addr == RESULT_ADDR);
   assign pin_sel_sel = (bus_req.addr == PIN_SEL_ADDR);

   assign mode_wr   = mode_sel & (bus_req.wr | bus_req.bit_op);
   assign pin_wr    = pin_sel_sel & bus_req.wr & ~bus_req.bit_op;

   assign next_mode = sas_mode_s'(apply_write(mode, bus_req));

   // ---------------------------------------------------------------
   // Mode register
   // ---------------------------------------------------------------

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         mode <= sas_mode_s'(MODE_RESET);
      end else if (mode_wr) begin
         mode <= next_mode;
      end
   end

   assign chan_sel = mode.chan_sel;

   // ---------------------------------------------------------------
   // Analog pin select
   // ---------------------------------------------------------------

   // Pin select takes whole-byte writes only; a bit operation on it is ignored.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pin_count <= PIN_SEL_RESET;
      end else if (pin_wr) begin
         pin_count <= bus_req.wdata[PIN_CNT_W-1:0];
      end
   end

   // Enables decode the incoming count, so they move at the write edge.
   assign next_pin_count = pin_wr ? bus_req.wdata[PIN_CNT_W-1:0] : pin_count;

   // A prohibited count above eight routes no pin at all.
   for (genvar i = 0; i < CHAN_COUNT; i++) begin : g_pin_en
      assign next_pin_en[i] = (next_pin_count <= PIN_COUNT_MAX) &&
                              (PIN_CNT_W'(i) < next_pin_count);
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         analog_pin_en <= '0;
      end else begin
         analog_pin_en <= next_pin_en;
      end
   end

   // ---------------------------------------------------------------
   // Trigger
   // ---------------------------------------------------------------

   assign trig_enable = mode.run & mode.ext_trigger_sel;

   sas_trig_edge u_trig_edge (
      .clk_sys        (clk_sys),
      .reset_n        (reset_n),
      .ext_trigger_in (ext_trigger_in),
      .enable         (trig_enable),
      .fall_pulse     (trig_pulse)
   );

   // ---------------------------------------------------------------
   // Sequencing strobes
   // ---------------------------------------------------------------

   // A mode write in the same cycle as a slot end wins: the decision is
   // dropped so an aborted conversion never reaches the result register.
   assign cnt_zero    = (cnt == '0);

   assign sample_end  = (state == ST_SAMPLE) & cnt_zero & ~mode_wr;
   assign bit_decide  = (state == ST_CONVERT) & cnt_zero & ~mode_wr;
   assign last_decide = bit_decide & (bit_idx == '0);

   assign begin_conv = (next_state == ST_SAMPLE) &&
                       ((state != ST_SAMPLE) || mode_wr);

   assign start_time_sel = mode_wr ?
                           {next_mode.conv_time_sel_hi, next_mode.conv_time_sel_lo} :
                           {mode.conv_time_sel_hi, mode.conv_time_sel_lo};

   assign new_slot = slot_len(start_time_sel);

   // ---------------------------------------------------------------
   // State machine
   // ---------------------------------------------------------------

   // A mode write outranks every state and aborts a conversion.
   always_comb begin
      next_state = state;
      if (mode_wr) begin
         if (!next_mode.run) begin
            next_state = ST_IDLE;
         end else if (next_mode.ext_trigger_sel) begin
            next_state = ST_WAIT_TRIG;
         end else begin
            next_state = ST_SAMPLE;
         end
      end else begin
         case (state)
            ST_IDLE: begin
               next_state = ST_IDLE;
            end
            ST_WAIT_TRIG: begin
               if (trig_pulse) begin
                  next_state = ST_SAMPLE;
               end
            end
            ST_SAMPLE: begin
               if (cnt_zero) begin
                  next_state = ST_CONVERT;
               end
            end
            ST_CONVERT: begin
               if (cnt_zero && (bit_idx == '0)) begin
                  if (mode.ext_trigger_sel) begin
                     next_state = ST_WAIT_TRIG;
                  end else begin
                     next_state = ST_SAMPLE;
                  end
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ---------------------------------------------------------------
   // Pacing counter
   // ---------------------------------------------------------------

   // Two slots of sampling and one slot per bit make ten slots, which is
   // exactly the selected conversion length in clock periods.
   always_comb begin
      next_cnt = cnt;
      if (begin_conv) begin
         next_cnt = SLOT_W'(new_slot * SAMPLE_SLOTS - 1);
      end else if (sample_end || (bit_decide && !last_decide)) begin
         next_cnt = slot_q - 1'b1;
      end else if (!cnt_zero) begin
         next_cnt = cnt - 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         slot_q <= SLOT_STD;
      end else if (begin_conv) begin
         slot_q <= new_slot;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bit_idx <= BIT_TOP;
      end else if (sample_end) begin
         bit_idx <= BIT_TOP;
      end else if (bit_decide) begin
         bit_idx <= bit_idx - 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Front-end controls
   // ---------------------------------------------------------------

   // Hold drops at the edge that stores the result.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         sample_en <= 1'b0;
         hold_en   <= 1'b0;
      end else begin
         sample_en <= (next_state == ST_SAMPLE);
         hold_en   <= (next_state == ST_CONVERT);
      end
   end

   // ---------------------------------------------------------------
   // Approximation register
   // ---------------------------------------------------------------

   sas_approx u_approx (
      .clk_sys    (clk_sys),
      .reset_n    (reset_n),
      .clear      (sample_end),
      .decide     (bit_decide),
      .cmp_ge     (cmp_ge),
      .trial_code (trial_code),
      .result     (result),
      .done       (conv_done_irq)
   );

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------

   // Result is read-only; neither byte writes nor bit operations touch it.
   assign next_rdata = !bus_req.rd ? READ_ZERO :
                       mode_sel    ? DATA_W'(mode) :
                       result_sel  ? result :
                       pin_sel_sel ? DATA_W'(pin_count) :
                                     READ_ZERO;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         bus_rdata <= READ_ZERO;
      end else begin
         bus_rdata <= next_rdata;
      end
   end

endmodule

// file: shared/sas_pkg.sv
/*
 Constants, field layouts and carrier types shared by the converter sequencer
 and its two leaf modules. Assumes one system clock and an active-low reset.
*/
package sas_pkg;

   // ---------------------------------------------------------------
   // Widths and register map
   // ---------------------------------------------------------------
   localparam int unsigned DATA_W      = 8;
   localparam int unsigned CHAN_W      = 3;
   localparam int unsigned CHAN_COUNT  = 8;
   localparam int unsigned PIN_CNT_W   = 4;
   localparam int unsigned SLOT_W      = 8;

   localparam logic [15:0] MODE_ADDR    = 16'hff80;
   localparam logic [15:0] RESULT_ADDR  = 16'hff81;
   localparam logic [15:0] PIN_SEL_ADDR = 16'hff84;

   localparam logic [DATA_W-1:0]    MODE_RESET    = 8'h01;
   localparam logic [DATA_W-1:0]    RESULT_RESET  = 8'h00;
   localparam logic [DATA_W-1:0]    READ_ZERO     = 8'h00;
   localparam logic [PIN_CNT_W-1:0] PIN_SEL_RESET = 4'h0;
   localparam logic [PIN_CNT_W-1:0] PIN_COUNT_MAX = 4'h8;
   localparam logic [DATA_W-1:0]    MSB_CODE      = 8'h80;
   localparam logic [CHAN_W-1:0]    BIT_TOP       = 3'h7;
   localparam logic                 TRIG_IDLE     = 1'b1;

   // ---------------------------------------------------------------
   // Conversion timing, in main clock periods
   // ---------------------------------------------------------------
   localparam logic [1:0] TSEL_STD  = 2'h0;
   localparam logic [1:0] TSEL_FAST = 2'h1;
   localparam logic [1:0] TSEL_LONG = 2'h2;

   localparam int unsigned CLKS_STD       = 160;
   localparam int unsigned CLKS_FAST      = 80;
   localparam int unsigned CLKS_LONG      = 200;
   localparam int unsigned SLOTS_PER_CONV = 10;
   localparam int unsigned SAMPLE_SLOTS   = 2;

   localparam logic [SLOT_W-1:0] SLOT_STD  = SLOT_W'(CLKS_STD / SLOTS_PER_CONV);
   localparam logic [SLOT_W-1:0] SLOT_FAST = SLOT_W'(CLKS_FAST / SLOTS_PER_CONV);
   localparam logic [SLOT_W-1:0] SLOT_LONG = SLOT_W'(CLKS_LONG / SLOTS_PER_CONV);

   // ---------------------------------------------------------------
   // Carrier types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              run;
      logic              ext_trigger_sel;
      logic              conv_time_sel_hi;
      logic              conv_time_sel_lo;
      logic [CHAN_W-1:0] chan_sel;
      logic              fixed_one;
   } sas_mode_s;

   typedef struct packed {
      logic [15:0]       addr;
      logic              wr;
      logic              bit_op;
      logic [2:0]        bit_sel;
      logic              bit_val;
      logic              rd;
      logic [DATA_W-1:0] wdata;
   } sas_bus_req_s;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_WAIT_TRIG,
      ST_SAMPLE,
      ST_CONVERT
   } sas_state_e;

endpackage

// file: hw/sas_trig_edge.sv
/*
 Falling-edge detector for the external conversion trigger.
 Assumes the trigger pin is already synchronous to clk_sys.
*/
module sas_trig_edge
   import sas_pkg::*;
(
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic reset_n,
   // Trigger
   input  wire logic ext_trigger_in,
   input  wire logic enable,
   output      logic fall_pulse
);

   logic trig_prev;

   // The previous level keeps tracking while gated, so enabling the trigger
   // never manufactures an edge from a pin that was already low.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         trig_prev <= TRIG_IDLE;
      end else begin
         trig_prev <= ext_trigger_in;
      end
   end

   assign fall_pulse = enable & trig_prev & ~ext_trigger_in;

endmodule

// file: hw/sas_approx.sv
/*
 Successive approximation register with result latch and completion pulse.
 Assumes clear and decide are one-cycle strobes from the sequencer.
*/
module sas_approx
   import sas_pkg::*;
(
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   // Control
   input  wire logic              clear,
   input  wire logic              decide,
   input  wire logic              cmp_ge,
   // Results
   output      logic [DATA_W-1:0] trial_code,
   output      logic [DATA_W-1:0] result,
   output      logic              done
);

   logic [DATA_W-1:0] bit_mask;
   logic [DATA_W-1:0] kept_code;
   logic              last_bit;

   assign kept_code = cmp_ge ? trial_code : (trial_code & ~bit_mask);
   assign last_bit  = decide & bit_mask[0];

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         trial_code <= READ_ZERO;
         bit_mask   <= READ_ZERO;
      end else if (clear) begin
         trial_code <= MSB_CODE;
         bit_mask   <= MSB_CODE;
      end else if (decide) begin
         trial_code <= kept_code | (bit_mask >> 1);
         bit_mask   <= bit_mask >> 1;
      end
   end

   // Result resets to zero only so the port is defined; software treats it as
   // undefined until the first completion.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         result <= RESULT_RESET;
      end else if (last_bit) begin
         result <= kept_code;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         done <= 1'b0;
      end else begin
         done <= last_bit;
      end
   end

endmodule

// file: test/sas_sequencer_properties.sv
/*
 Checker for the converter sequencer, bound to its top ports.
 Assumes one clock and an active-low asynchronous reset.
*/
module sas_seq_chk
   import sas_pkg::*;
(
   // Clock and reset
   input wire logic                  clk_sys,
   input wire logic                  reset_n,
   // Register port
   input wire sas_bus_req_s          bus_req,
   input wire logic [DATA_W-1:0]     bus_rdata,
   // Trigger and front end
   input wire logic                  ext_trigger_in,
   input wire logic                  cmp_ge,
   input wire logic [DATA_W-1:0]     trial_code,
   input wire logic                  sample_en,
   input wire logic                  hold_en,
   input wire logic [CHAN_W-1:0]     chan_sel,
   input wire logic [CHAN_COUNT-1:0] analog_pin_en,
   input wire logic                  conv_done_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Helper logic
   // ---------------------------------------------------------------
   logic [7:0]        hold_cnt;
   logic [7:0]        samp_cnt;
   logic [DATA_W-1:0] low_bit;
   logic              mode_wr;
   logic              pin_wr;

   assign low_bit = trial_code & (~trial_code + 8'h01);
   assign mode_wr = bus_req.wr & ~bus_req.bit_op & (bus_req.addr == MODE_ADDR);
   assign pin_wr  = bus_req.wr & ~bus_req.bit_op & (bus_req.addr == PIN_SEL_ADDR) & (bus_req.wdata[3:0] <= 4'h8);

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         hold_cnt <= 8'h00;
         samp_cnt <= 8'h00;
      end else begin
         hold_cnt <= hold_en ? hold_cnt + 8'h01 : 8'h00;
         samp_cnt <= sample_en ? samp_cnt + 8'h01 : 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence s_hold_min;
      hold_en [*8] ##1 hold_en [*8];
   endsequence
   sequence s_step;
      hold_en && $past(hold_en) && $changed(trial_code);
   endsequence

   property p_done_end; conv_done_irq |-> $fell(hold_en); endproperty
   property p_hold_len; $fell(hold_en) && conv_done_irq |-> hold_cnt inside {8'h40, 8'h80, 8'ha0}; endproperty
   property p_samp_len; $rose(hold_en) |-> $past(sample_en) && samp_cnt inside {8'h10, 8'h20, 8'h28}; endproperty
   property p_first; $rose(hold_en) |-> trial_code == MSB_CODE; endproperty
   property p_walk; s_step |-> (low_bit << 1) == $past(low_bit); endproperty
   property p_keep; s_step |-> ((trial_code & $past(low_bit)) != 8'h00) == $past(cmp_ge); endproperty
   property p_hold_min; $rose(hold_en) |-> s_hold_min; endproperty
   property p_rdata; !$past(bus_req.rd) |-> bus_rdata == READ_ZERO; endproperty
   property p_chan; mode_wr |=> chan_sel == $past(bus_req.wdata[3:1]); endproperty
   property p_pins; pin_wr |=> analog_pin_en == (8'hff >> (4'h8 - $past(bus_req.wdata[3:0]))); endproperty

   a_done_end: assert property (p_done_end) else $error("done off hold end");
   a_hold_len: assert property (p_hold_len) else $error("hold length");
   a_samp_len: assert property (p_samp_len) else $error("sample length");
   a_first: assert property (p_first) else $error("first trial");
   a_walk: assert property (p_walk) else $error("trial order");
   a_keep: assert property (p_keep) else $error("bit decision");
   a_hold_min: assert property (p_hold_min) else $error("hold short");
   a_rdata: assert property (p_rdata) else $error("read data idle");
   a_chan: assert property (p_chan) else $error("channel select");
   a_pins: assert property (p_pins) else $error("pin enables");
endmodule

bind sas_sequencer sas_seq_chk u_chk (
   .clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
   .ext_trigger_in(ext_trigger_in), .cmp_ge(cmp_ge), .trial_code(trial_code),
   .sample_en(sample_en), .hold_en(hold_en), .chan_sel(chan_sel),
   .analog_pin_en(analog_pin_en), .conv_done_irq(conv_done_irq)
);

// file: test/sas_front_model.sv
/*
 Comparator front end: compares the held channel level with the trial code.
 Assumes levels come from the bench; slow adds one cycle of answer delay.
*/
module sas_front_model
   import sas_pkg::*;
(
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              reset_n,
   // Sequencer side
   input wire logic [DATA_W-1:0] trial_code,
   input wire logic [CHAN_W-1:0] chan_sel,
   input wire logic              hold_en,
   output     logic              cmp_ge,
   // Bench side
   input wire logic [63:0]       vin_all,
   input wire logic              slow
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [DATA_W-1:0] level;
   logic              cmp_now;
   logic              cmp_dly;

   assign level  = vin_all[chan_sel*DATA_W +: DATA_W];
   assign cmp_ge = slow ? cmp_dly : cmp_now;

   // Outside hold the answer is meaningless, so it toggles to expose early use.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cmp_now <= 1'b0;
         cmp_dly <= 1'b0;
      end else begin
         cmp_now <= hold_en ? (level >= trial_code) : ~cmp_now;
         cmp_dly <= cmp_now;
      end
   end
endmodule

// file: test/tb.sv
/*
 Self-checking bench for the converter sequencer.
 Assumes the front-end model and the bound checker are compiled with it.
*/
module tb
   import sas_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------------------------
   // Signals
   // ---------------------------------------------------------------
   logic                  clk_sys;
   logic                  reset_n;
   sas_bus_req_s          bus_req;
   logic [DATA_W-1:0]     bus_rdata;
   logic                  ext_trigger_in;
   logic                  cmp_ge;
   logic [DATA_W-1:0]     trial_code;
   logic                  sample_en;
   logic                  hold_en;
   logic [CHAN_W-1:0]     chan_sel;
   logic [CHAN_COUNT-1:0] analog_pin_en;
   logic                  conv_done_irq;
   logic [63:0]           vin_all;
   logic                  slow;
   int                    n_errors;
   int                    n_compared;

   sas_sequencer DUT (
      .clk_sys(clk_sys), .reset_n(reset_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
      .ext_trigger_in(ext_trigger_in), .cmp_ge(cmp_ge), .trial_code(trial_code),
      .sample_en(sample_en), .hold_en(hold_en), .chan_sel(chan_sel),
      .analog_pin_en(analog_pin_en), .conv_done_irq(conv_done_irq)
   );
   sas_front_model u_front (
      .clk_sys(clk_sys), .reset_n(reset_n), .trial_code(trial_code), .chan_sel(chan_sel),
      .hold_en(hold_en), .cmp_ge(cmp_ge), .vin_all(vin_all), .slow(slow)
   );

   // ---------------------------------------------------------------
   // Tasks and reference functions
   // ---------------------------------------------------------------
   task automatic end_sim();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_cnt(input string what, input int exp, input int got);
      n_compared++;
      if (got != exp) begin
         n_errors++;
         $display("[ERR] %s expected %0d seen %0d", what, exp, got);
      end
   endtask
   task automatic bus(input sas_bus_req_s r);
      @(negedge clk_sys);
      bus_req = r;
      @(negedge clk_sys);
      bus_req = '0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      bus('{addr: a, wr: 1'b1, wdata: d, default: '0});
   endtask
   task automatic bit_wr(input logic [15:0] a, input logic [2:0] s, input logic v);
      bus('{addr: a, bit_op: 1'b1, bit_sel: s, bit_val: v, default: '0});
   endtask
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      bus('{addr: a, rd: 1'b1, default: '0});
      d = bus_rdata;
   endtask
   // Counts falling edges until the completion pulse, at most lim of them.
   task automatic wait_done(input int lim, output int c);
      c = 0;
      do begin
         @(negedge clk_sys);
         c++;
      end while (c < lim && conv_done_irq !== 1'b1);
   endtask
   task automatic trig();
      @(negedge clk_sys);
      ext_trigger_in = 1'b0;
      repeat (4) @(negedge clk_sys);
      ext_trigger_in = 1'b1;
   endtask
   function automatic logic [7:0] sar_ref(input logic [7:0] v);
      logic [7:0] code;
      code = 8'h00;
      for (int b = 7; b >= 0; b--) begin
         if (v >= (code | (8'h01 << b))) begin
            code = code | (8'h01 << b);
         end
      end
      return code;
   endfunction
   function automatic int clks(input logic [1:0] ts);
      return ts == TSEL_FAST ? CLKS_FAST : ts == TSEL_STD ? CLKS_STD : CLKS_LONG;
   endfunction
   task automatic conv_sw(input logic [1:0] ts, input logic [2:0] ch, input logic [7:0] v, input logic s);
      int n;
      int c;
      logic [7:0] r;
      n = clks(ts);
      vin_all = {$urandom, $urandom};
      vin_all[ch*8 +: 8] = v;
      slow = s;
      wr(MODE_ADDR, {2'b10, ts, ch, 1'b1});
      cmp8("chan_sel", 8'(ch), 8'(chan_sel));
      wait_done(n + 4, c);
      cmp_cnt("conv_clocks", n, c);
      vin_all[ch*8 +: 8] = ~v;
      rd(RESULT_ADDR, r);
      cmp8("result", sar_ref(v), r);
      wait_done(n + 4, c);
      cmp_cnt("repeat_clocks", n - 2, c);
      rd(RESULT_ADDR, r);
      cmp8("reload", sar_ref(~v), r);
      wr(MODE_ADDR, 8'h01);
      wait_done(n + 4, c);
      cmp_cnt("stopped", n + 4, c);
   endtask

   // ---------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ---------------------------------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   // The tests need about 5000 cycles; the margin covers slow variants.
   initial begin
      repeat (20000) @(posedge clk_sys);
      n_errors++;
      end_sim();
   end
   initial begin
      logic [7:0] r;
      logic [7:0] r2;
      int c;
      reset_n = 1'b0;
      bus_req = '0;
      ext_trigger_in = TRIG_IDLE;
      vin_all = '0;
      slow = 1'b0;
      n_errors = 0;
      n_compared = 0;
      void'($urandom(54));
      repeat (10) @(negedge clk_sys);
      reset_n = 1'b1;
      rd(MODE_ADDR, r);
      cmp8("mode_reset", MODE_RESET, r);
      for (int i = 0; i <= 8; i++) begin
         wr(PIN_SEL_ADDR, 8'(i));
         cmp8("pin_en", 8'hff >> (8 - i), analog_pin_en);
      end
      for (int i = 0; i < 8; i++) begin
         conv_sw(2'(i % 3), 3'(i), i == 0 ? 8'hff : i == 1 ? 8'h00 : 8'($urandom), i == 7);
      end
      conv_sw(2'h3, 3'h4, 8'($urandom), 1'b1);
      rd(RESULT_ADDR, r);
      wr(RESULT_ADDR, ~r);
      rd(RESULT_ADDR, r2);
      cmp8("result_ro", r, r2);
      rd(16'hff90, r);
      cmp8("unmapped", READ_ZERO, r);
      vin_all = {$urandom, $urandom};
      wr(MODE_ADDR, 8'h95);
      repeat (40) @(negedge clk_sys);
      wr(MODE_ADDR, 8'h9b);
      wait_done(90, c);
      cmp_cnt("abort_restart", 80, c);
      rd(RESULT_ADDR, r);
      cmp8("abort_result", sar_ref(vin_all[47:40]), r);
      wr(MODE_ADDR, 8'h01);
      bit_wr(MODE_ADDR, 3'h7, 1'b1);
      wait_done(170, c);
      cmp_cnt("bit_start", 160, c);
      rd(MODE_ADDR, r);
      cmp8("mode_bit_set", 8'h81, r);
      bit_wr(MODE_ADDR, 3'h7, 1'b0);
      rd(MODE_ADDR, r);
      cmp8("mode_bit_clr", 8'h01, r);
      wr(MODE_ADDR, 8'h51);
      trig();
      wait_done(200, c);
      cmp_cnt("trig_stopped", 200, c);
      wr(MODE_ADDR, 8'hd1);
      wait_done(50, c);
      cmp_cnt("armed_idle", 50, c);
      trig();
      repeat (20) @(negedge clk_sys);
      trig();
      wait_done(90, c);
      cmp_cnt("trig_start", 52, c);
      wait_done(240, c);
      cmp_cnt("one_per_trig", 240, c);
      end_sim();
   end
endmodule
